// >>> core/tpc_pkg.sv
// constants and carrier types for the two-phase pulse counter
package tpc_pkg;

  // register byte offsets
  localparam logic [7:0] TPC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] TPC_OFS_MODE   = 8'h04;
  localparam logic [7:0] TPC_OFS_STATUS = 8'h08;
  localparam logic [7:0] TPC_OFS_COUNT2 = 8'h10;
  localparam logic [7:0] TPC_OFS_COUNT3 = 8'h14;
  localparam logic [7:0] TPC_OFS_COUNT4 = 8'h18;

  // count_start_flags: run_enable_bit of channel 2+k at bit k
  localparam int TPC_RUN_POS     = 0;
  // mode word field positions
  localparam int TPC_TWOPH_POS   = 0;   // two_phase_enable_bit, 3 bits
  localparam int TPC_FREE_POS    = 4;   // free-running select, 3 bits
  localparam int TPC_X4_POS      = 8;   // multiply-by-4 select, channel 3
  localparam int TPC_IDXEN_POS   = 9;   // index_reset_enable
  localparam int TPC_POL_POS     = 10;  // edge_polarity_bit
  localparam int TPC_TRIG_POS    = 12;  // trigger_select_high/low, 2 bits each
  localparam int TPC_NCH         = 3;

  // writable bits and values after reset
  localparam logic [31:0] TPC_CTRL_MASK  = 32'h0000_0007;
  localparam logic [31:0] TPC_MODE_MASK  = 32'h0003_F777;
  localparam logic [31:0] TPC_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] TPC_MODE_RST   = 32'h0000_0000;
  localparam logic [15:0] TPC_COUNT_RST  = 16'h0000;

  // counter limits and trigger code for the input pin
  localparam logic [15:0] TPC_CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] TPC_CNT_MIN    = 16'h0000;
  localparam logic [1:0]  TPC_TRIG_PIN   = 2'h0;

  // bus answers
  localparam logic [1:0]  TPC_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  TPC_RESP_SLVERR = 2'h2;

  typedef enum logic {TPC_DOWN, TPC_UP} tpc_dir_e;

  // per-channel configuration
  typedef struct packed {
    logic       run;
    logic       two_phase;
    logic       free_run;
    logic       x4;
    logic       idx_en;
    logic       edge_polarity_bit;
    logic [1:0] trig;
  } tpc_chcfg_s;

  // per-channel register write strobe with its data
  typedef struct packed {
    logic        en;
    logic [15:0] data;
  } tpc_chwr_s;

endpackage

// >>> core/tpc_counter.sv
// two-phase pulse counter: channel core and AXI4-Lite register top
`timescale 1ns/1ps

// one counter channel with pin synchronisers and decoder
// Notes on behaviour
// - two-phase count from phase pins, channels 2-4
// - wrap reloads counter unless free-running
// - free-running wraps without reload
// - up divides by FFFF-n+1, down by n+1
// - run bit starts and stops counting
// - request pulse on each overflow or underflow
// - count read returns live counter
// - stopped write loads reload and counter
// - running write loads reload only
// - normal decode, b high: a rise up, fall down
// - x4: b high at a rise, all edges up
// - x4: b high at a fall, all edges down
// - x4 choosable on channel 3 only
// - event mode: b low down, b high up
// - index reset on channel 3, free-run or x4
// - index from its pin, only while enabled
// - index edge polarity chosen by polarity bit
// - counter cleared cycle after index detection
// - wrap with index reset gives two requests
module tpc_channel #(
  parameter int CH = 2
) (
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire tpc_pkg::tpc_chcfg_s cfg,
  input  wire tpc_pkg::tpc_chwr_s  wr,
  input  wire logic                a_pin,
  input  wire logic                b_pin,
  input  wire logic                z_pin,
  output logic [15:0]              count,
  output logic                     dir,
  output logic                     irq
);
  import tpc_pkg::*;

  typedef struct packed {
    logic        a1, a2, a3, af;
    logic        b1, b2, b3, bf;
    logic        z1, z2, z3, zf;
    tpc_dir_e    dir;
    logic [15:0] cnt;
    logic [15:0] rel;
    logic        zpend;
    logic        irq;
    logic        irq2;
  } tpc_chst_s;

  tpc_chst_s s_q, s_d;
  logic a_edge, b_edge, z_edge, ar, af, b_lvl;
  logic step_up, step_dn, wrap, use_x4, zok, zdet, pin_src;

  // mode decode per channel
  assign use_x4 = (CH == 4) ? 1'b1 : (CH == 3) ? cfg.x4 : 1'b0;
  assign zok    = (CH == 3) && cfg.idx_en && cfg.two_phase &&
                  (cfg.free_run || use_x4);
  assign pin_src = (cfg.trig == TPC_TRIG_PIN);

  // next-state logic
  always_comb begin
    s_d     = s_q;
    step_up = 1'b0;
    step_dn = 1'b0;
    wrap    = 1'b0;
    // three-stage synchronisers, level moves once stages 2 and 3 agree
    s_d.a1 = a_pin;
    s_d.a2 = s_q.a1;
    s_d.a3 = s_q.a2;
    s_d.b1 = b_pin;
    s_d.b2 = s_q.b1;
    s_d.b3 = s_q.b2;
    s_d.z1 = z_pin;
    s_d.z2 = s_q.z1;
    s_d.z3 = s_q.z2;
    a_edge = (s_q.a2 == s_q.a3) && (s_q.a3 != s_q.af);
    b_edge = (s_q.b2 == s_q.b3) && (s_q.b3 != s_q.bf);
    z_edge = (s_q.z2 == s_q.z3) && (s_q.z3 != s_q.zf);
    if (a_edge) begin
      s_d.af = s_q.a3;
    end
    if (b_edge) begin
      s_d.bf = s_q.b3;
    end
    if (z_edge) begin
      s_d.zf = s_q.z3;
    end
    ar    = a_edge && s_d.af;
    af    = a_edge && !s_d.af;
    b_lvl = s_d.bf;
    // count events from the pins
    if (cfg.run && pin_src) begin
      if (cfg.two_phase) begin
        if (use_x4) begin
          if (ar && b_lvl) begin
            s_d.dir = TPC_UP;
          end else if (af && b_lvl) begin
            s_d.dir = TPC_DOWN;
          end
          if (a_edge || b_edge) begin
            step_up = (s_d.dir == TPC_UP);
            step_dn = (s_d.dir == TPC_DOWN);
          end
        end else begin
          step_up = ar && b_lvl;
          step_dn = af && b_lvl;
          if (step_up) begin
            s_d.dir = TPC_UP;
          end else if (step_dn) begin
            s_d.dir = TPC_DOWN;
          end
        end
      end else begin
        // plain event counting, direction from the second pin
        step_up = ar && b_lvl;
        step_dn = ar && !b_lvl;
        s_d.dir = b_lvl ? TPC_UP : TPC_DOWN;
      end
    end
    // counter step with overflow and underflow handling
    if (step_up) begin
      if (s_q.cnt == TPC_CNT_MAX) begin
        wrap  = 1'b1;
        s_d.cnt = cfg.free_run ? TPC_CNT_MIN : s_q.rel;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end else if (step_dn) begin
      if (s_q.cnt == TPC_CNT_MIN) begin
        wrap  = 1'b1;
        s_d.cnt = cfg.free_run ? TPC_CNT_MAX : s_q.rel;
      end else begin
        s_d.cnt = s_q.cnt - 16'h0001;
      end
    end
    // software write of the count/reload value
    if (wr.en) begin
      s_d.rel = wr.data;
      if (!cfg.run) begin
        s_d.cnt = wr.data;
      end
    end
    // index edge, applied on the following cycle
    zdet      = zok && z_edge && (s_d.zf == cfg.edge_polarity_bit);
    s_d.zpend = zdet;
    if (s_q.zpend) begin
      s_d.cnt = TPC_CNT_MIN;
    end
    // request pulses, doubled when a wrap meets an index reset
    s_d.irq  = wrap || s_q.irq2;
    s_d.irq2 = wrap && s_q.zpend;
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q     <= '0;
      s_q.dir <= TPC_UP;
      s_q.cnt <= TPC_COUNT_RST;
      s_q.rel <= TPC_COUNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
  assign dir   = (s_q.dir == TPC_UP);
  assign irq   = s_q.irq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wrap_irq_a: assert property (wrap |=> irq)
    else $error("wrap without interrupt request");
  stop_hold_a: assert property (
    !cfg.run && !wr.en && !s_q.zpend |=> $stable(s_q.cnt))
    else $error("counter moved while stopped");
  reload_a: assert property (
    wrap && !cfg.free_run && !wr.en && !s_q.zpend
      |=> s_q.cnt == $past(s_q.rel))
    else $error("reload value not loaded on wrap");
  free_wrap_a: assert property (
    step_up && cfg.free_run && s_q.cnt == TPC_CNT_MAX && !s_q.zpend
      |=> s_q.cnt == TPC_CNT_MIN)
    else $error("free-running counter did not wrap");
  stop_write_a: assert property (
    wr.en && !cfg.run && !s_q.zpend |=> s_q.cnt == $past(wr.data))
    else $error("stopped write missed the counter");
  run_write_a: assert property (
    wr.en && cfg.run |=> s_q.rel == $past(wr.data))
    else $error("running write missed the reload register");
  normal_up_a: assert property (
    cfg.run && cfg.two_phase && !use_x4 && pin_src && ar && b_lvl &&
    s_q.cnt != TPC_CNT_MAX && !s_q.zpend && !wr.en
      |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
    else $error("normal decode did not count up");
  index_rst_a: assert property (zdet |=> ##1 s_q.cnt == TPC_CNT_MIN)
    else $error("index edge did not clear the counter");
  double_irq_a: assert property (wrap && s_q.zpend |=> irq ##1 irq)
    else $error("coincident wrap and index gave one request");
  x4_cov: cover property (cfg.two_phase && use_x4 && step_dn);
  wrap_cov: cover property (wrap && !cfg.free_run);
  index_cov: cover property (zdet ##2 step_up);
endmodule

// register top: AXI4-Lite slave feeding three channels
module tpc_counter (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  phase_a_pin,
  input  wire logic [2:0]  phase_b_pin,
  input  wire logic        index_input_pin,
  output logic [2:0]       irq_req
);
  import tpc_pkg::*;

  typedef struct packed {
    logic        aw_ok;
    logic [7:0]  aw_addr;
    logic        w_ok;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] ctrl;
    logic [31:0] mode;
  } tpc_bus_s;

  tpc_bus_s     s_q, s_d;
  tpc_chcfg_s   cfg   [TPC_NCH];
  tpc_chwr_s    chwr  [TPC_NCH];
  logic [15:0]  cnt   [TPC_NCH];
  logic [2:0]   dirs;
  logic         do_wr;
  logic [31:0]  wval;

  // byte-lane merge of write data over an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // configuration fan-out and channel instances
  for (genvar g = 0; g < TPC_NCH; g++) begin : g_ch
    assign cfg[g].run       = s_q.ctrl[TPC_RUN_POS + g];
    assign cfg[g].two_phase = s_q.mode[TPC_TWOPH_POS + g];
    assign cfg[g].free_run  = s_q.mode[TPC_FREE_POS + g];
    assign cfg[g].x4        = s_q.mode[TPC_X4_POS];
    assign cfg[g].idx_en    = s_q.mode[TPC_IDXEN_POS];
    assign cfg[g].edge_polarity_bit       = s_q.mode[TPC_POL_POS];
    assign cfg[g].trig      = s_q.mode[TPC_TRIG_POS + 2*g +: 2];
    tpc_channel #(.CH(g + 2)) u_ch (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .cfg     (cfg[g]),
      .wr      (chwr[g]),
      .a_pin   (phase_a_pin[g]),
      .b_pin   (phase_b_pin[g]),
      .z_pin   (index_input_pin),
      .count   (cnt[g]),
      .dir     (dirs[g]),
      .irq     (irq_req[g])
    );
  end

  // write strobes into the channels
  always_comb begin
    for (int k = 0; k < TPC_NCH; k++) begin
      chwr[k].en   = do_wr && (s_q.aw_addr == TPC_OFS_COUNT2 + 8'(4 * k));
      chwr[k].data = 16'(merge({16'h0000, cnt[k]}, s_q.w_data, s_q.w_strb));
    end
  end

  // bus handshakes, register writes and read mux
  always_comb begin
    s_d   = s_q;
    do_wr = s_q.aw_ok && s_q.w_ok && !s_q.bvalid;
    wval  = 32'h0000_0000;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_ok   = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_ok   = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (do_wr) begin
      s_d.aw_ok  = 1'b0;
      s_d.w_ok   = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = TPC_RESP_OKAY;
      case (s_q.aw_addr)
        TPC_OFS_CTRL: begin
          wval = merge(s_q.ctrl, s_q.w_data, s_q.w_strb);
          s_d.ctrl = wval & TPC_CTRL_MASK;
        end
        TPC_OFS_MODE: begin
          wval = merge(s_q.mode, s_q.w_data, s_q.w_strb);
          s_d.mode = wval & TPC_MODE_MASK;
        end
        TPC_OFS_STATUS, TPC_OFS_COUNT2, TPC_OFS_COUNT3,
        TPC_OFS_COUNT4: begin
          s_d.bresp = TPC_RESP_OKAY;
        end
        default: begin
          s_d.bresp = TPC_RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = TPC_RESP_OKAY;
      case (s_axi_araddr)
        TPC_OFS_CTRL:   s_d.rdata = s_q.ctrl;
        TPC_OFS_MODE:   s_d.rdata = s_q.mode;
        TPC_OFS_STATUS: s_d.rdata = {29'h0000_0000, dirs};
        TPC_OFS_COUNT2: s_d.rdata = {16'h0000, cnt[0]};
        TPC_OFS_COUNT3: s_d.rdata = {16'h0000, cnt[1]};
        TPC_OFS_COUNT4: s_d.rdata = {16'h0000, cnt[2]};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = TPC_RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // bus state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q      <= '0;
      s_q.ctrl <= TPC_CTRL_RST;
      s_q.mode <= TPC_MODE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // channel ready terms and answers
  assign s_axi_awready = !s_q.aw_ok && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_ok && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  read_count_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == TPC_OFS_COUNT3
      |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(cnt[1]))
    else $error("count read did not return the live value");
  write_resp_a: assert property (
    s_q.aw_ok && s_q.w_ok && !s_q.bvalid |=> s_axi_bvalid)
    else $error("write answer missing");
  rd_cov: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// >>> sim/tpc_encoder.sv
// incremental encoder model driving phase and index pins
`timescale 1ns/1ps

module tpc_encoder (
  input  wire logic  ref_clk,
  output logic [2:0] phase_a_pin,
  output logic [2:0] phase_b_pin,
  output logic       index_input_pin
);
  logic [1:0] pos [3] = '{default: 2'h0};

  // rest: phase a low, phase b high, index low
  initial begin
    phase_a_pin = 3'h0;
    phase_b_pin = 3'h7;
    index_input_pin = 1'b0;
  end

  // quarter steps in gray order 01 11 10 00 when going up;
  // each level held seven cycles to clear the synchronisers
  task automatic step(input int ch, input logic up, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      pos[ch] = up ? pos[ch] + 2'h1 : pos[ch] - 2'h1;
      phase_a_pin[ch] <= pos[ch][0] ^ pos[ch][1];
      phase_b_pin[ch] <= ~pos[ch][1];
      repeat (6) @(posedge ref_clk);
    end
  endtask

  // rising index pulse, well over one count clock wide
  task automatic zpulse();
    @(posedge ref_clk);
    index_input_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    index_input_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask

  // index rise one cycle ahead of a quarter step, so the index
  // reset falls on the same cycle as that step's count
  task automatic zstep(input int ch, input logic up);
    @(posedge ref_clk);
    index_input_pin <= 1'b1;
    step(ch, up, 1);
    index_input_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule

// >>> sim/tb.sv
// self-checking bench for the two-phase pulse counter
`timescale 1ns/1ps

module tb;
  import tpc_pkg::*;

  logic        ref_clk       = 1'b0;
  logic        reset_n       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata   = 32'h0000_0000;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  logic [2:0]  phase_a_pin;
  logic [2:0]  phase_b_pin;
  logic        index_input_pin;
  logic [2:0]  irq_req;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;
  logic [1:0]  wr_resp;
  int          bad_count     = 0;
  int          compares      = 0;
  int          cyc           = 0;
  int          irq_n [3]     = '{0, 0, 0};

  tpc_counter dut (
    .ref_clk,
    .reset_n,
    .s_axi_awaddr,
    .s_axi_awvalid,
    .s_axi_awready,
    .s_axi_wdata,
    .s_axi_wstrb (4'hF),
    .s_axi_wvalid,
    .s_axi_wready,
    .s_axi_bresp,
    .s_axi_bvalid,
    .s_axi_bready,
    .s_axi_araddr,
    .s_axi_arvalid,
    .s_axi_arready,
    .s_axi_rdata,
    .s_axi_rresp,
    .s_axi_rvalid,
    .s_axi_rready,
    .phase_a_pin,
    .phase_b_pin,
    .index_input_pin,
    .irq_req
  );

  tpc_encoder enc (
    .ref_clk,
    .phase_a_pin,
    .phase_b_pin,
    .index_input_pin
  );

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  // irq pulse tally and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    for (int i = 0; i < 3; i++)
      if (irq_req[i] === 1'b1) irq_n[i]++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // read: data and response taken at the rvalid edge
  task automatic axr(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_word = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdchk(input string w, input logic [7:0] a,
                       input logic [31:0] exp);
    axr(a);
    chk(w, rd_word, exp);
  endtask

  // values after reset and an unmapped read
  task automatic t_reset();
    rdchk("ctrl", TPC_OFS_CTRL, TPC_CTRL_RST);
    rdchk("mode", TPC_OFS_MODE, TPC_MODE_RST);
    rdchk("count3", TPC_OFS_COUNT3, {16'h0000, TPC_COUNT_RST});
    axr(8'h0C);
    chk("unmapped", {30'h0, rd_resp}, {30'h0, TPC_RESP_SLVERR});
    axw(8'h0C, 32'h0000_0001);
    chk("unmapped wr", {30'h0, wr_resp}, {30'h0, TPC_RESP_SLVERR});
  endtask

  // channel 2 normal decoding, x4 bit set but ignored, start and stop
  task automatic t_normal();
    axw(TPC_OFS_MODE, 32'h0000_0101);
    axw(TPC_OFS_COUNT2, 32'h0000_0010);
    rdchk("load stopped", TPC_OFS_COUNT2, 32'h0000_0010);
    axw(TPC_OFS_CTRL, 32'h0000_0001);
    enc.step(0, 1'b1, 12);
    rdchk("normal up", TPC_OFS_COUNT2, 32'h0000_0013);
    enc.step(0, 1'b0, 4);
    rdchk("normal down", TPC_OFS_COUNT2, 32'h0000_0012);
    axw(TPC_OFS_CTRL, 32'h0000_0000);
    enc.step(0, 1'b1, 4);
    rdchk("stopped", TPC_OFS_COUNT2, 32'h0000_0012);
    rdchk("status", TPC_OFS_STATUS, 32'h0000_0006);
  endtask

  // write while running reaches the counter only at underflow
  task automatic t_reload();
    int n;
    axw(TPC_OFS_COUNT2, 32'h0000_0001);
    axw(TPC_OFS_CTRL, 32'h0000_0001);
    axw(TPC_OFS_COUNT2, 32'h0000_0005);
    rdchk("reload only", TPC_OFS_COUNT2, 32'h0000_0001);
    n = irq_n[0];
    enc.step(0, 1'b0, 8);
    rdchk("underflow", TPC_OFS_COUNT2, 32'h0000_0005);
    chk("irq ch2", 32'(irq_n[0] - n), 32'h0000_0001);
    axw(TPC_OFS_CTRL, 32'h0000_0000);
  endtask

  // channel 4 always x4: n=FFFE gives an overflow every two edges
  task automatic t_x4();
    int n;
    axw(TPC_OFS_MODE, 32'h0000_0004);
    axw(TPC_OFS_COUNT4, 32'h0000_FFFE);
    axw(TPC_OFS_CTRL, 32'h0000_0004);
    n = irq_n[2];
    enc.step(2, 1'b1, 4);
    rdchk("x4 wrap", TPC_OFS_COUNT4, 32'h0000_FFFE);
    chk("irq ch4", 32'(irq_n[2] - n), 32'h0000_0002);
    axw(TPC_OFS_CTRL, 32'h0000_0000);
  endtask

  // channel 3 free-running underflow wraps to FFFF, not the reload
  task automatic t_free();
    int n;
    axw(TPC_OFS_MODE, 32'h0000_0022);
    axw(TPC_OFS_COUNT3, 32'h0000_0000);
    axw(TPC_OFS_CTRL, 32'h0000_0002);
    n = irq_n[1];
    enc.step(1, 1'b0, 4);
    rdchk("free wrap", TPC_OFS_COUNT3, 32'h0000_FFFF);
    chk("irq ch3", 32'(irq_n[1] - n), 32'h0000_0001);
    axw(TPC_OFS_CTRL, 32'h0000_0000);
  endtask

  // index pulse clears channel 3 only while enabled
  task automatic t_index();
    axw(TPC_OFS_COUNT3, 32'h0000_0000);
    axw(TPC_OFS_MODE, 32'h0000_0622);
    axw(TPC_OFS_CTRL, 32'h0000_0002);
    enc.step(1, 1'b1, 8);
    rdchk("pre index", TPC_OFS_COUNT3, 32'h0000_0002);
    enc.zpulse();
    rdchk("index clear", TPC_OFS_COUNT3, 32'h0000_0000);
    axw(TPC_OFS_MODE, 32'h0000_0422);
    enc.step(1, 1'b1, 4);
    enc.zpulse();
    rdchk("index off", TPC_OFS_COUNT3, 32'h0000_0001);
    axw(TPC_OFS_CTRL, 32'h0000_0000);
  endtask

  // underflow on the index reset cycle gives two requests
  task automatic t_double();
    int n;
    axw(TPC_OFS_COUNT3, 32'h0000_0000);
    axw(TPC_OFS_MODE, 32'h0000_0622);
    axw(TPC_OFS_CTRL, 32'h0000_0002);
    n = irq_n[1];
    enc.step(1, 1'b0, 3);
    enc.zstep(1, 1'b0);
    rdchk("double clear", TPC_OFS_COUNT3, 32'h0000_0000);
    chk("double irq", 32'(irq_n[1] - n), 32'h0000_0002);
    axw(TPC_OFS_CTRL, 32'h0000_0000);
  endtask

  // channel 3 x4: reverse steps count up until a fall of a with b high
  task automatic t_x4sel();
    axw(TPC_OFS_MODE, 32'h0000_0102);
    axw(TPC_OFS_COUNT3, 32'h0000_0100);
    axw(TPC_OFS_CTRL, 32'h0000_0002);
    enc.step(1, 1'b1, 4);
    rdchk("x4 ch3 up", TPC_OFS_COUNT3, 32'h0000_0104);
    enc.step(1, 1'b0, 8);
    rdchk("x4 ch3 dn", TPC_OFS_COUNT3, 32'h0000_0102);
    axw(TPC_OFS_CTRL, 32'h0000_0000);
  endtask

  // channel 2 event counting with phase b as direction
  task automatic t_event();
    axw(TPC_OFS_MODE, 32'h0000_0000);
    axw(TPC_OFS_COUNT2, 32'h0000_0010);
    axw(TPC_OFS_CTRL, 32'h0000_0001);
    enc.step(0, 1'b1, 4);
    rdchk("event up", TPC_OFS_COUNT2, 32'h0000_0011);
    enc.step(0, 1'b0, 2);
    enc.step(0, 1'b1, 2);
    rdchk("event dn", TPC_OFS_COUNT2, 32'h0000_0010);
  endtask

  // reset, settle the pin synchronisers, run the scenarios
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    t_reset();
    t_normal();
    t_reload();
    t_x4();
    t_free();
    t_index();
    t_double();
    t_x4sel();
    t_event();
    complete_run();
  end
endmodule
